/* core/tpw_pkg.sv */
// Constants for the three-phase dead-time PWM generator
package tpw_pkg;
  localparam int DW = 16;
  localparam int AW = 8;
  localparam logic [DW-1:0] REG_RESET = 16'hFFFF;
  localparam logic [DW-1:0] ZERO16 = 16'h0000;
  localparam logic [DW-1:0] ONE16 = 16'h0001;
  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AW-1:0] OFS_DEAD = 8'h08;
  localparam logic [AW-1:0] OFS_HALFBUF = 8'h0C;
  localparam logic [AW-1:0] OFS_PERIOD = 8'h10;
  localparam logic [AW-1:0] OFS_COUNT = 8'h14;
  localparam logic [AW-1:0] OFS_BUF_U = 8'h18;
  localparam logic [AW-1:0] OFS_BUF_V = 8'h1C;
  localparam logic [AW-1:0] OFS_BUF_W = 8'h20;
  localparam logic [AW-1:0] OFS_FREE_U = 8'h24;
  localparam logic [AW-1:0] OFS_FREE_V = 8'h28;
  localparam logic [AW-1:0] OFS_FREE_W = 8'h2C;
  // Control register fields
  localparam int CTRL_W = 11;
  localparam int B_RUN = 0;
  localparam int B_CONVERTER_TRIGGER_ENABLE = 1;
  localparam int B_CREST_IE = 2;
  localparam int B_TROUGH_IE = 3;
  localparam int B_XFER_CREST = 4;
  localparam int B_XFER_TROUGH = 5;
  localparam int B_POSITIVE_LEVEL_SELECT = 6;
  localparam int B_NEGATIVE_LEVEL_SELECT = 7;
  localparam int B_SYNC_OUT = 8;
  localparam int B_DMA_CREST = 9;
  localparam int B_DMA_TROUGH = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h0C0;
  // Status register fields
  localparam int B_CREST_F = 0;
  localparam int B_TROUGH_F = 1;
  localparam int PHASES = 3;
endpackage

/* core/tpw_phase.sv */
// One PWM phase: compare registers, compare waves, dead time, pin levels
`timescale 1ns/100ps
module tpw_phase
  import tpw_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [DW-1:0] count,
  input wire logic countUp,
  input wire logic [DW-1:0] deadTime,
  input wire logic load,
  input wire logic [DW-1:0] loadValue,
  input wire logic positive_level_select,
  input wire logic negative_level_select,
  output logic posPin,
  output logic negPin
);
  typedef struct packed {
    logic [DW-1:0] centre;
    logic [DW-1:0] upCmp;
    logic [DW-1:0] downCmp;
    logic cmpPos;
    logic cmpNeg;
    logic [DW-1:0] dtPosCnt;
    logic [DW-1:0] dtNegCnt;
    logic dtPosRun;
    logic dtNegRun;
    logic posPin;
    logic negPin;
  } tpw_phase_s;

  tpw_phase_s st;
  tpw_phase_s next_st;

  // Advance one dead-time counter; returns {run, count}
  function automatic logic [DW:0] tpw_dt_step(input logic run,
      input logic [DW-1:0] cnt, input logic start, input logic [DW-1:0] td);
    logic [DW-1:0] inc;
    inc = cnt + ONE16;
    if (td == ZERO16) begin
      tpw_dt_step = {1'b0, ZERO16};
    end else if (run) begin
      if (inc == td) begin
        tpw_dt_step = {1'b0, ZERO16};
      end else begin
        tpw_dt_step = {1'b1, inc};
      end
    end else if (start) begin
      tpw_dt_step = {1'b1, ZERO16};
    end else begin
      tpw_dt_step = {1'b0, ZERO16};
    end
  endfunction

  always_comb begin
    logic genPos;
    logic genNeg;
    genPos = 1'b0;
    genNeg = 1'b0;
    next_st = st;
    if (load) begin
      next_st.centre = loadValue + deadTime;
      next_st.upCmp = loadValue + deadTime + deadTime;
      next_st.downCmp = loadValue;
    end
    if (countUp) begin
      next_st.cmpPos = !(st.upCmp > count);
      next_st.cmpNeg = st.centre > count;
    end else begin
      next_st.cmpPos = !(st.centre > count);
      next_st.cmpNeg = st.downCmp > count;
    end
    {next_st.dtPosRun, next_st.dtPosCnt} = tpw_dt_step(st.dtPosRun,
        st.dtPosCnt, st.cmpPos & !next_st.cmpPos, deadTime);
    {next_st.dtNegRun, next_st.dtNegCnt} = tpw_dt_step(st.dtNegRun,
        st.dtNegCnt, st.cmpNeg & !next_st.cmpNeg, deadTime);
    // Dead-time wave is the inverse of the running flag
    genPos = next_st.cmpPos & !next_st.dtNegRun;
    genNeg = next_st.cmpNeg & !next_st.dtPosRun;
    next_st.posPin = positive_level_select ? genPos : !genPos;
    next_st.negPin = negative_level_select ? genNeg : !genNeg;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '{centre: REG_RESET, upCmp: REG_RESET, downCmp: REG_RESET,
              cmpPos: 1'b0, cmpNeg: 1'b0, dtPosCnt: ZERO16,
              dtNegCnt: ZERO16, dtPosRun: 1'b0, dtNegRun: 1'b0,
              posPin: 1'b0, negPin: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign posPin = st.posPin;
  assign negPin = st.negPin;
endmodule

/* core/tpw_top.sv */
// Three-phase dead-time PWM generator with APB register slave
`timescale 1ns/100ps
module tpw_top
  import tpw_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic syncIn,
  output logic syncOut,
  output logic syncOe,
  input wire logic clockStopped,
  input wire logic dmaAck,
  output logic [PHASES-1:0] posPin,
  output logic [PHASES-1:0] negPin,
  output logic [PHASES-1:0] posOe,
  output logic [PHASES-1:0] negOe,
  output logic crestIrq,
  output logic troughIrq,
  output logic dmaReq,
  output logic adcTrigger
);
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [DW-1:0] deadTime;
    logic [DW-1:0] halfBuf;
    logic [DW-1:0] period;
    logic [DW-1:0] count;
    logic countUp;
    logic [PHASES-1:0][DW-1:0] dutyBuf;
    logic crestFlag;
    logic troughFlag;
    logic crestArmed;
    logic troughArmed;
    logic dmaCrest;
    logic syncPrev;
    logic syncOut;
    logic oe;
    logic crestIrq;
    logic troughIrq;
    logic dmaReq;
    logic adcTrigger;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tpw_top_s;

  tpw_top_s st;
  tpw_top_s next_st;
  logic [PHASES-1:0] phaseLoad;
  logic [PHASES-1:0][DW-1:0] phaseValue;
  logic [PHASES-1:0] posRaw;
  logic [PHASES-1:0] negRaw;

  // Decodes one address into its duty-buffer phase, or PHASES if none
  function automatic int tpw_phase_of(input logic [AW-1:0] a,
      input logic freeAddr);
    tpw_phase_of = PHASES;
    if (!freeAddr) begin
      if (a == OFS_BUF_U) tpw_phase_of = 0;
      if (a == OFS_BUF_V) tpw_phase_of = 1;
      if (a == OFS_BUF_W) tpw_phase_of = 2;
    end else begin
      if (a == OFS_FREE_U) tpw_phase_of = 0;
      if (a == OFS_FREE_V) tpw_phase_of = 1;
      if (a == OFS_FREE_W) tpw_phase_of = 2;
    end
  endfunction

  function automatic logic tpw_mapped(input logic [AW-1:0] a);
    tpw_mapped = (a == OFS_CTRL) || (a == OFS_STATUS) ||
        (a == OFS_DEAD) || (a == OFS_HALFBUF) || (a == OFS_PERIOD) ||
        (a == OFS_COUNT) || (tpw_phase_of(a, 1'b0) != PHASES) ||
        (tpw_phase_of(a, 1'b1) != PHASES);
  endfunction

  always_comb begin
    logic access;
    logic wrDone;
    logic rdDone;
    logic run;
    logic [DW-1:0] twoTd;
    logic [DW-1:0] wdata;
    logic crestHit;
    logic troughHit;
    logic transfer;
    logic clearEdge;
    logic [DW-1:0] newHalf;
    access = 1'b0;
    wrDone = 1'b0;
    rdDone = 1'b0;
    run = 1'b0;
    twoTd = ZERO16;
    wdata = ZERO16;
    crestHit = 1'b0;
    troughHit = 1'b0;
    transfer = 1'b0;
    clearEdge = 1'b0;
    newHalf = ZERO16;
    phaseLoad = '0;
    phaseValue = st.dutyBuf;
    next_st = st;

    // APB: one wait state, the access completes when pready is seen high
    access = psel && penable;
    next_st.pready = access && !st.pready;
    wrDone = access && st.pready && pwrite;
    rdDone = access && st.pready && !pwrite;
    wdata = pwdata[DW-1:0];
    next_st.pslverr = access && !st.pready && !tpw_mapped(paddr);
    next_st.prdata = 32'h00000000;
    if (access && !st.pready && !pwrite) begin
      unique case (1'b1)
        paddr == OFS_CTRL: next_st.prdata[CTRL_W-1:0] = st.ctrl;
        paddr == OFS_STATUS: begin
          next_st.prdata[B_CREST_F] = st.crestFlag;
          next_st.prdata[B_TROUGH_F] = st.troughFlag;
        end
        paddr == OFS_DEAD: next_st.prdata[DW-1:0] = st.deadTime;
        paddr == OFS_HALFBUF: next_st.prdata[DW-1:0] = st.halfBuf;
        paddr == OFS_PERIOD: next_st.prdata[DW-1:0] = st.period;
        paddr == OFS_COUNT: next_st.prdata[DW-1:0] = st.count;
        tpw_phase_of(paddr, 1'b0) != PHASES:
          next_st.prdata[DW-1:0] = st.dutyBuf[tpw_phase_of(paddr, 1'b0)];
        tpw_phase_of(paddr, 1'b1) != PHASES:
          next_st.prdata[DW-1:0] = st.dutyBuf[tpw_phase_of(paddr, 1'b1)];
        default: next_st.prdata = 32'h00000000;
      endcase
    end

    run = st.ctrl[B_RUN];
    twoTd = st.deadTime + st.deadTime;

    // Register writes
    newHalf = st.halfBuf;
    if (wrDone) begin
      if (paddr == OFS_CTRL) next_st.ctrl = pwdata[CTRL_W-1:0];
      if (paddr == OFS_DEAD) next_st.deadTime = wdata;
      if (paddr == OFS_HALFBUF) begin
        next_st.halfBuf = wdata;
        newHalf = wdata;
      end
      if (paddr == OFS_PERIOD) next_st.period = wdata;
      // Counter takes its starting value only while stopped
      if (paddr == OFS_COUNT && !run) next_st.count = wdata;
      if (tpw_phase_of(paddr, 1'b0) != PHASES) begin
        next_st.dutyBuf[tpw_phase_of(paddr, 1'b0)] = wdata;
      end
      if (tpw_phase_of(paddr, 1'b1) != PHASES) begin
        next_st.dutyBuf[tpw_phase_of(paddr, 1'b1)] = wdata;
        phaseLoad[tpw_phase_of(paddr, 1'b1)] = 1'b1;
        phaseValue[tpw_phase_of(paddr, 1'b1)] = wdata;
      end
    end

    // Carrier counter
    crestHit = run && st.countUp && (st.count == st.period);
    troughHit = run && !st.countUp && (st.count == twoTd);
    clearEdge = !st.ctrl[B_SYNC_OUT] && st.syncPrev && !syncIn;
    next_st.syncPrev = syncIn;
    if (run) begin
      if (clearEdge) begin
        next_st.count = twoTd;
        next_st.countUp = 1'b1;
      end else if (st.countUp) begin
        if (st.count >= st.period) begin
          next_st.countUp = 1'b0;
          next_st.count = st.count - ONE16;
        end else begin
          next_st.count = st.count + ONE16;
        end
      end else begin
        if (st.count <= twoTd) begin
          next_st.countUp = 1'b1;
          next_st.count = st.count + ONE16;
        end else begin
          next_st.count = st.count - ONE16;
        end
      end
    end
    next_st.syncOut = next_st.countUp;

    // Buffer transfer; a write in the same cycle transfers its own data
    transfer = (crestHit && st.ctrl[B_XFER_CREST]) ||
        (troughHit && st.ctrl[B_XFER_TROUGH]);
    if (transfer) begin
      // Period is compared only at the crest, hence falls out here
      next_st.period = newHalf + twoTd;
      phaseLoad = {PHASES{1'b1}};
      phaseValue = next_st.dutyBuf;
    end

    // Flags: set wins over both software and DMA clears
    if (rdDone && paddr == OFS_STATUS) begin
      next_st.crestArmed = st.crestFlag;
      next_st.troughArmed = st.troughFlag;
    end
    if (wrDone && paddr == OFS_STATUS) begin
      if (st.crestArmed && !pwdata[B_CREST_F]) next_st.crestFlag = 1'b0;
      if (st.troughArmed && !pwdata[B_TROUGH_F]) begin
        next_st.troughFlag = 1'b0;
      end
      next_st.crestArmed = 1'b0;
      next_st.troughArmed = 1'b0;
    end
    if (dmaAck && st.dmaReq) begin
      if (st.dmaCrest) next_st.crestFlag = 1'b0;
      else next_st.troughFlag = 1'b0;
    end
    if (crestHit) next_st.crestFlag = 1'b1;
    if (troughHit) next_st.troughFlag = 1'b1;
    next_st.crestIrq = next_st.crestFlag && st.ctrl[B_CREST_IE];
    next_st.troughIrq = next_st.troughFlag && st.ctrl[B_TROUGH_IE];
    if (next_st.crestFlag && st.ctrl[B_DMA_CREST]) begin
      next_st.dmaReq = 1'b1;
      next_st.dmaCrest = 1'b1;
    end else if (next_st.troughFlag && st.ctrl[B_DMA_TROUGH]) begin
      next_st.dmaReq = 1'b1;
      next_st.dmaCrest = 1'b0;
    end else begin
      next_st.dmaReq = 1'b0;
    end
    next_st.adcTrigger = (crestHit || troughHit) && st.ctrl[B_CONVERTER_TRIGGER_ENABLE];
    // Clock-stop signal from the clock monitor; pins float while it stands
    next_st.oe = !clockStopped;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
      st.deadTime <= REG_RESET;
      st.halfBuf <= REG_RESET;
      st.period <= REG_RESET;
      st.countUp <= 1'b1;
      st.dutyBuf <= {PHASES{REG_RESET}};
      st.syncPrev <= 1'b1;
      st.syncOut <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PHASES; gi++) begin : g_phase
      // Each phase sees the same carrier but loads its own duty value, so V and W do not track U
      tpw_phase u_phase (
        .clk(clk),
        .reset(reset),
        .count(st.count),
        .countUp(st.countUp),
        .deadTime(st.deadTime),
        .load(phaseLoad[gi]),
        .loadValue(phaseValue[gi]),
        .positive_level_select(st.ctrl[B_POSITIVE_LEVEL_SELECT]),
        .negative_level_select(st.ctrl[B_NEGATIVE_LEVEL_SELECT]),
        .posPin(posRaw[gi]),
        .negPin(negRaw[gi])
      );
    end
  endgenerate

  assign posPin = posRaw;
  assign negPin = negRaw;
  assign posOe = {PHASES{st.oe}};
  assign negOe = {PHASES{st.oe}};
  assign syncOut = st.syncOut;
  assign syncOe = st.ctrl[B_SYNC_OUT];
  assign crestIrq = st.crestIrq;
  assign troughIrq = st.troughIrq;
  assign dmaReq = st.dmaReq;
  assign adcTrigger = st.adcTrigger;
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
endmodule

/* sim/tpw_props.sv */
// Port-level assertions for the three-phase PWM generator
`timescale 1ns/100ps
module tpw_props
  import tpw_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic syncIn,
  input wire logic syncOut,
  input wire logic syncOe,
  input wire logic clockStopped,
  input wire logic dmaAck,
  input wire logic [PHASES-1:0] posPin,
  input wire logic [PHASES-1:0] negPin,
  input wire logic [PHASES-1:0] posOe,
  input wire logic [PHASES-1:0] negOe,
  input wire logic crestIrq,
  input wire logic troughIrq,
  input wire logic dmaReq,
  input wire logic adcTrigger
);
  // ====================
  // Control shadow
  logic [CTRL_W-1:0] ctrl;
  logic [PHASES-1:0] genPos;
  logic [PHASES-1:0] genNeg;
  // Level select is rebuilt from completed writes, so pins can be unmapped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
    end else if (psel && penable && pready && pwrite && paddr == OFS_CTRL) begin
      ctrl <= pwdata[CTRL_W-1:0];
    end
  end
  assign genPos = ctrl[B_POSITIVE_LEVEL_SELECT] ? posPin : ~posPin;
  assign genNeg = ctrl[B_NEGATIVE_LEVEL_SELECT] ? negPin : ~negPin;
  // ====================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not after exactly one wait state");
  chk_stop_hiz: assert property (
    clockStopped |=> posOe == '0 && negOe == '0)
    else $error("pins still driven after clock stop");
  chk_no_overlap: assert property (
    $stable(ctrl) && $past(ctrl) == $past(ctrl, 2) && (&posOe)
    |-> (genPos & genNeg) == '0)
    else $error("both phases active together");
  chk_crest_irq: assert property (
    crestIrq |-> $past(ctrl[B_CREST_IE]))
    else $error("crest interrupt while disabled");
  chk_trough_irq: assert property (
    troughIrq |-> $past(ctrl[B_TROUGH_IE]))
    else $error("trough interrupt while disabled");
  chk_dma_clear: assert property (dmaAck |-> ##[1:2] !dmaReq)
    else $error("dma request kept after dma access");
  chk_adc_gate: assert property (
    adcTrigger |-> $past(ctrl[B_CONVERTER_TRIGGER_ENABLE]) ##1 !adcTrigger)
    else $error("converter trigger wrong");
  chk_sync_oe: assert property (syncOe == ctrl[B_SYNC_OUT])
    else $error("sync pin direction wrong");
endmodule

bind tpw_top tpw_props tpw_props_i (.clk, .reset, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .syncIn,
  .syncOut, .syncOe, .clockStopped, .dmaAck, .posPin, .negPin, .posOe,
  .negOe, .crestIrq, .troughIrq, .dmaReq, .adcTrigger);

/* sim/tpw_partner.sv */
// Far-side model: sync/clear source on a pulled-up pin and DMA controller
`timescale 1ns/100ps
module tpw_partner (
  input wire logic clk,
  input wire logic reset,
  input wire logic dmaReq,
  input wire logic clearOn,
  input wire logic [3:0] ackDelay,
  input wire logic syncOe,
  input wire logic syncOut,
  output logic syncLine,
  output logic dmaAck
);
  // ====================
  // Pin and DMA behaviour
  logic [3:0] waitCnt;
  logic [3:0] phase;
  logic clearLvl;
  // Pull-up keeps the line high while syncOe is low, except for the clearOn low pulses
  assign syncLine = syncOe ? syncOut : clearLvl;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      waitCnt <= 4'h0;
      phase <= 4'h0;
      clearLvl <= 1'b1;
      dmaAck <= 1'b0;
    end else begin
      clearLvl <= !(clearOn && phase == 4'h0);
      phase <= (phase == 4'h5) ? 4'h0 : phase + 4'h1;
      dmaAck <= 1'b0;
      if (dmaReq && !dmaAck) begin
        if (waitCnt == ackDelay) begin
          dmaAck <= 1'b1;
          waitCnt <= 4'h0;
        end else begin
          waitCnt <= waitCnt + 4'h1;
        end
      end
    end
  end
endmodule

/* sim/tpw_top_tb.sv */
// Self-checking bench for the three-phase dead-time PWM generator
`timescale 1ns/100ps
module tpw_top_tb;
  import tpw_pkg::*;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, clockStopped = 1'b0, clearOn = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, syncIn, syncOut, syncOe, dmaAck, dmaReq;
  logic [PHASES-1:0] posPin, negPin, posOe, negOe;
  logic crestIrq, troughIrq, adcTrigger, lastErr, andV, orU, andN;
  int failures = 0, checkCount = 0, n, per, hi;

  tpw_top tpw_top_i (.clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .syncIn, .syncOut, .syncOe,
    .clockStopped, .dmaAck, .posPin, .negPin, .posOe, .negOe,
    .crestIrq, .troughIrq, .dmaReq, .adcTrigger);
  tpw_partner tpw_partner_i (.clk, .reset, .dmaReq, .clearOn,
    .ackDelay(4'h3), .syncOe, .syncOut, .syncLine(syncIn), .dmaAck);

  initial forever #12.5 clk = ~clk;

  // ====================
  // Tasks
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [AW-1:0] a,
      input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) failures++;
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string what, input logic [AW-1:0] a,
      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask
  task automatic sync_period();
    int t;
    t = 0;
    while (syncOut !== 1'b0 && t < 99) begin @(posedge clk); t++; end
    while (syncOut !== 1'b1 && t < 99) begin @(posedge clk); t++; end
    hi = 0;
    while (syncOut === 1'b1 && hi < 99) begin @(posedge clk); hi++; end
    per = hi;
    while (syncOut === 1'b0 && per < 199) begin @(posedge clk); per++; end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #150000;
    failures++;
    $display("BAD watchdog expected finish seen hang");
    final_report;
  end

  // ====================
  // Tests
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdchk("ctrl", OFS_CTRL, 32'h0C0);
    rdchk("dead", OFS_DEAD, 32'hFFFF);
    rdchk("halfbuf", OFS_HALFBUF, 32'hFFFF);
    rdchk("period", OFS_PERIOD, 32'hFFFF);
    rdchk("status", OFS_STATUS, 32'h0);
    rdchk("unmapped", 8'h30, 32'h0);
    check("slverr", 32'h1, {31'h0, lastErr});
    $display("test reset values done");
    wr(OFS_DEAD, 32'h2);
    wr(OFS_HALFBUF, 32'hA);
    wr(OFS_PERIOD, 32'h1E);
    wr(OFS_COUNT, 32'h4);
    wr(OFS_FREE_U, 32'h0);
    wr(OFS_FREE_V, 32'h1);
    wr(OFS_FREE_W, 32'h5);
    repeat (6) @(posedge clk);
    check("pos init", 32'h1, {29'h0, posPin});
    check("neg init", 32'h4, {29'h0, negPin});
    wr(OFS_CTRL, 32'h030);
    repeat (3) @(posedge clk);
    check("pos low", 32'h6, {29'h0, posPin});
    check("neg low", 32'h3, {29'h0, negPin});
    $display("test initial output done");
    wr(OFS_CTRL, 32'h0E0);
    wr(OFS_BUF_U, 32'h5);
    repeat (3) @(posedge clk);
    check("pos buffered", 32'h1, {31'h0, posPin[0]});
    wr(OFS_FREE_U, 32'h14);
    repeat (3) @(posedge clk);
    check("pos free", 32'h0, {31'h0, posPin[0]});
    wr(OFS_FREE_V, 32'h0);
    $display("test buffer writes done");
    wr(OFS_CTRL, 32'h3EF);
    repeat (70) @(posedge clk);
    rdchk("period xfer", OFS_PERIOD, 32'hE);
    sync_period();
    check("carrier period", 32'd20, per);
    check("sync high", 32'd10, hi);
    andV = 1'b1;
    orU = 1'b0;
    andN = 1'b1;
    repeat (40) begin
      @(posedge clk);
      andV = andV & posPin[1];
      orU = orU | posPin[0];
      andN = andN & negPin[0];
    end
    check("full duty", 32'h1, {31'h0, andV});
    check("zero duty", 32'h0, {31'h0, orU});
    check("neg down", 32'h1, {31'h0, andN});
    wr(OFS_CTRL, 32'h3EE);
    wr(OFS_STATUS, 32'h0);
    rdchk("status dma", OFS_STATUS, 32'h2);
    check("trough irq", 32'h1, {31'h0, troughIrq});
    wr(OFS_STATUS, 32'h0);
    rdchk("status clr", OFS_STATUS, 32'h0);
    check("irq clr", 32'h0, {31'h0, troughIrq});
    $display("test carrier and flags done");
    clearOn <= 1'b1;
    wr(OFS_CTRL, 32'h2EF);
    repeat (20) @(posedge clk);
    n = 0;
    repeat (60) begin @(posedge clk); n += int'(adcTrigger === 1'b1); end
    check("adc held", 32'd0, n);
    wr(OFS_CTRL, 32'h2EE);
    apb(1'b0, OFS_COUNT, 32'h0);
    check("count clr", 32'h1, {31'h0, rd >= 32'h4 && rd <= 32'hA});
    clearOn <= 1'b0;
    wr(OFS_CTRL, 32'h2EF);
    repeat (5) @(posedge clk);
    n = 0;
    repeat (40) begin @(posedge clk); n += int'(adcTrigger === 1'b1); end
    check("adc count", 32'd4, n);
    $display("test external clear done");
    clockStopped <= 1'b1;
    repeat (3) @(posedge clk);
    check("oe stop", 32'h0, {26'h0, posOe, negOe});
    clockStopped <= 1'b0;
    $display("test clock stop done");
    final_report;
  end
endmodule
